// file: logic/codec_ctl_cfg.svh
// constants for the codec serial control port
`ifndef CODEC_CTL_CFG_SVH
`define CODEC_CTL_CFG_SVH
`define DEV_ADDR_ID       5'h1A  // arbitrary value
`define CHIP_ADDR_BITS    2'h2
`define REG_COUNT         6
`define WRITE_LAST_ADDR   5'h05
`define READ_LAST_ADDR    5'h0D
`define ADDR_RESET_AND_MUTE 5'h00
`define ADDR_POWER_SPEED    5'h01
`define ADDR_FORMAT         5'h02
`define ADDR_DEEMPH         5'h03
`define ADDR_CLOCK          5'h04
`define ADDR_INSEL          5'h05
`define RST_R0            8'h01
`define RST_R1            8'h70
`define RST_R2            8'h0F
`define RST_R3            8'h50
`define RST_R4            8'h00
`define RST_R5            8'h10
`define MASK_R0           8'h07
`define MASK_R1           8'h77
`define MASK_R2           8'h0F
`define MASK_R3           8'hF0
`define MASK_R4           8'h77
`define MASK_R5           8'h7F
`define BIT_TIMING_RST    0
`define BIT_UNMUTE_A      1
`define BIT_UNMUTE_B      2
`define BIT_PORTB_AUTO    2
`define BIT_ADC_PWR       4
`define BIT_DACA_PWR      5
`define BIT_DACB_PWR      6
`define BIT_PORTA_AUTO    6
`define SAMPLE_RATE_HZ    48000
`define CLK_HZ            50000000
`define FS_CYCLES         (`CLK_HZ / `SAMPLE_RATE_HZ)
`define TIMING_RST_FS     4
`endif

// file: logic/codec_ctl_pkg.sv
// types for the codec serial control port
package codec_ctl_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_ACK   = 3'b010,
    ST_RX    = 3'b011,
    ST_TX    = 3'b100,
    ST_TXACK = 3'b101
  } i2c_state_t;
  typedef enum logic [1:0] {
    PH_DEV  = 2'b00,
    PH_REG  = 2'b01,
    PH_DATA = 2'b10
  } byte_phase_t;
endpackage

// file: logic/timing_reset_delay.sv
// delays the clearing of the codec timing reset by a few sample periods
`timescale 1ns/1ps
`include "codec_ctl_cfg.svh"
module timing_reset_delay
  import codec_ctl_pkg::*;
#(
  parameter int FS_CYC = `FS_CYCLES,
  parameter int N_FS   = `TIMING_RST_FS
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic req_n,
  output logic      int_n
);
  localparam int CNT_MAX = FS_CYC * N_FS;
  initial if (CNT_MAX < 1 || CNT_MAX > 65535) $error("bad delay");
  typedef struct packed {
    logic [15:0] cnt;
    logic        out_n;
  } st_t;
  st_t s_r, s_nxt;
  always_comb begin
    s_nxt = s_r;
    if (req_n) begin
      s_nxt.cnt   = 16'h0000;
      s_nxt.out_n = 1'b1;
    end else if (s_r.out_n) begin
      // clearing takes effect only after the sample-period delay
      if (s_r.cnt == 16'(CNT_MAX - 1)) s_nxt.out_n = 1'b0;
      else s_nxt.cnt = s_r.cnt + 16'h0001;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) s_r <= '{cnt: 16'h0000, out_n: 1'b1};
    else s_r <= s_nxt;
  end
  assign int_n = s_r.out_n;
  delay_len_a: assert property (@(posedge clk) disable iff (rst)
    $fell(s_r.out_n) |-> !$past(req_n) && $past(s_r.cnt) == 16'(CNT_MAX - 1))
    else $error("timing reset fell before its delay");
  release_fast_a: assert property (@(posedge clk) disable iff (rst)
    req_n |=> s_r.out_n)
    else $error("timing reset not released");
endmodule

// file: logic/i2c_edge_detect.sv
// samples the serial pins and flags clock edges, start and stop
`timescale 1ns/1ps
module i2c_edge_detect (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // pins
  input  wire logic scl,
  input  wire logic sda,
  // events
  output logic      scl_rise,
  output logic      scl_fall,
  output logic      start,
  output logic      stop,
  output logic      sda_now
);
  typedef struct packed {
    logic scl_d;
    logic sda_d;
  } st_t;
  st_t s_r, s_nxt;
  always_comb begin
    s_nxt.scl_d = scl;
    s_nxt.sda_d = sda;
  end
  always_ff @(posedge clk) begin
    if (rst) s_r <= '{scl_d: 1'b1, sda_d: 1'b1};
    else s_r <= s_nxt;
  end
  assign scl_rise = scl & ~s_r.scl_d;
  assign scl_fall = ~scl & s_r.scl_d;
  // sda moving while scl stays high is a start or stop
  assign start    = scl & s_r.scl_d & s_r.sda_d & ~sda;
  assign stop     = scl & s_r.scl_d & ~s_r.sda_d & sda;
  assign sda_now  = sda;
endmodule

// file: logic/codec_i2c_control_regs.sv
// serial control port slave and control register bank of the codec
`timescale 1ns/1ps
`include "codec_ctl_cfg.svh"
module codec_i2c_control_regs
  import codec_ctl_pkg::*;
#(
  parameter logic [4:0] ID_CODE = `DEV_ADDR_ID  // arbitrary value
) (
  // clock and reset
  input  wire logic       CORE_CLK,
  input  wire logic       RST,
  // serial control pins
  input  wire logic       SCL,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  // device pins
  input  wire logic       POWERDOWN_PIN_N,
  input  wire logic       DAC_A_UNMUTE_PIN,
  input  wire logic       DAC_B_UNMUTE_PIN,
  input  wire logic       PORT_A_CLK_DETECT,
  input  wire logic       PORT_B_CLK_DETECT,
  // controls to the codec
  output logic            CODEC_TIMING_RESET_N,
  output logic            DAC_A_MUTED,
  output logic            DAC_B_MUTED,
  output logic            ADC_POWER_ON,
  output logic            DAC_A_POWER_ON,
  output logic            DAC_B_POWER_ON,
  output logic            PORT_A_SPEED_HI,
  output logic            PORT_B_SPEED_HI,
  output logic [1:0]      PORT_A_SPEED_SEL,
  output logic [1:0]      PORT_B_SPEED_SEL,
  output logic [3:0]      PORT_FORMAT_SEL,
  output logic [3:0]      DAC_DEEMPH_SEL,
  output logic [2:0]      PORT_A_MASTER_CLK_SEL,
  output logic [2:0]      MUTE_CLOCK_SRC_SEL,
  output logic [3:0]      ADC_INPUT_SEL
);
  localparam logic [6:0] MY_ADDR = {ID_CODE, `CHIP_ADDR_BITS};
  initial if (`REG_COUNT != 6) $error("register count mismatch");

  function automatic logic [7:0] reg_mask(input logic [4:0] a);
    case (a)
      5'h00:   reg_mask = `MASK_R0;
      5'h01:   reg_mask = `MASK_R1;
      5'h02:   reg_mask = `MASK_R2;
      5'h03:   reg_mask = `MASK_R3;
      5'h04:   reg_mask = `MASK_R4;
      5'h05:   reg_mask = `MASK_R5;
      default: reg_mask = 8'h00;
    endcase
  endfunction

  function automatic logic [4:0] next_addr(input logic [4:0] a, input logic [4:0] last);
    next_addr = (a >= last) ? 5'h00 : a + 5'h01;
  endfunction

  // ----------------------------------------
  // pin event detection
  // ----------------------------------------
  logic scl_rise, scl_fall, start_ev, stop_ev, sda_s;
  i2c_edge_detect u_edge (
    .clk      (CORE_CLK),
    .rst      (RST),
    .scl      (SCL),
    .sda      (SDA_IN),
    .scl_rise (scl_rise),
    .scl_fall (scl_fall),
    .start    (start_ev),
    .stop     (stop_ev),
    .sda_now  (sda_s)
  );

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    i2c_state_t  st;
    byte_phase_t ph;
    logic        rd;
    logic [2:0]  bitc;
    logic [7:0]  sh;
    logic [4:0]  addr;
    logic        oe;
    logic [7:0]  r0;
    logic [7:0]  r1;
    logic [7:0]  r2;
    logic [7:0]  r3;
    logic [7:0]  r4;
    logic [7:0]  r5;
    logic [14:0] outs;
  } st_t;
  st_t s_r, s_nxt;

  function automatic logic [7:0] rd_data(input st_t s);
    logic [7:0] v;
    v = 8'h00;
    case (s.addr)
      5'h00:   v = s.r0;
      5'h01:   v = s.r1;
      5'h02:   v = s.r2;
      5'h03:   v = s.r3;
      5'h04:   v = s.r4;
      5'h05:   v = s.r5;
      default: v = 8'h00;
    endcase
    rd_data = v & reg_mask(s.addr);
  endfunction

  logic timing_int_n;
  timing_reset_delay u_trst (
    .clk   (CORE_CLK),
    .rst   (RST),
    .req_n (s_r.r0[`BIT_TIMING_RST]),
    .int_n (timing_int_n)
  );

  // ----------------------------------------
  // protocol engine
  // ----------------------------------------
  always_comb begin
    logic [7:0] byte_in;
    logic [7:0] wdat;
    logic [7:0] rdv;
    byte_in = {s_r.sh[6:0], sda_s};
    wdat    = 8'h00;
    rdv     = rd_data(s_r);
    s_nxt   = s_r;
    case (s_r.st)
      ST_IDLE: s_nxt.oe = 1'b0;
      ST_ADDR, ST_RX: begin
        if (scl_rise) begin
          s_nxt.sh   = byte_in;
          s_nxt.bitc = s_r.bitc + 3'h1;
          if (s_r.bitc == 3'h7) s_nxt.st = ST_ACK;
        end
      end
      ST_ACK: begin
        if (scl_fall && !s_r.oe) begin
          s_nxt.oe = 1'b1;
          if (s_r.ph == PH_DEV) begin
            if (s_r.sh[7:1] != MY_ADDR) begin
              s_nxt.oe = 1'b0;
              s_nxt.st = ST_IDLE;
            end else s_nxt.rd = s_r.sh[0];
          end else if (s_r.ph == PH_REG) begin
            s_nxt.addr = {s_r.sh[4:0]};
          end else begin
            // only a full byte reaches here
            wdat = s_r.sh & reg_mask(s_r.addr);
            case (s_r.addr)
              5'h00:   s_nxt.r0 = wdat;
              5'h01:   s_nxt.r1 = wdat;
              5'h02:   s_nxt.r2 = wdat;
              5'h03:   s_nxt.r3 = wdat;
              5'h04:   s_nxt.r4 = wdat;
              5'h05:   s_nxt.r5 = wdat;
              default: wdat = 8'h00;
            endcase
            s_nxt.addr = next_addr(s_r.addr, `WRITE_LAST_ADDR);
          end
        end else if (scl_fall && s_r.oe) begin
          s_nxt.bitc = 3'h0;
          if (s_r.ph == PH_DEV && s_r.rd) begin
            s_nxt.st = ST_TX;
            s_nxt.sh = rdv;
            s_nxt.oe = !rdv[7];
          end else begin
            s_nxt.oe = 1'b0;
            s_nxt.st = ST_RX;
            s_nxt.ph = (s_r.ph == PH_DEV) ? PH_REG : PH_DATA;
          end
        end
      end
      ST_TX: begin
        if (scl_fall) begin
          s_nxt.bitc = s_r.bitc + 3'h1;
          s_nxt.sh   = {s_r.sh[6:0], 1'b0};
          if (s_r.bitc == 3'h7) begin
            s_nxt.oe   = 1'b0;
            s_nxt.st   = ST_TXACK;
            s_nxt.addr = next_addr(s_r.addr, `READ_LAST_ADDR);
          end else s_nxt.oe = !s_r.sh[6];
        end
      end
      ST_TXACK: begin
        if (scl_rise) begin
          if (sda_s) s_nxt.st = ST_IDLE;
          else s_nxt.bitc = 3'h0;
        end else if (scl_fall) begin
          s_nxt.st = ST_TX;
          s_nxt.sh = rdv;
          s_nxt.oe = !rdv[7];
        end
      end
      default: s_nxt.st = ST_IDLE;
    endcase
    if (start_ev) begin
      s_nxt.st   = ST_ADDR;
      s_nxt.ph   = PH_DEV;
      s_nxt.bitc = 3'h0;
      s_nxt.oe   = 1'b0;
    end else if (stop_ev) begin
      s_nxt.st = ST_IDLE;
      s_nxt.oe = 1'b0;
    end
    if (!POWERDOWN_PIN_N) begin
      s_nxt.r0 = `RST_R0;
      s_nxt.r1 = `RST_R1;
      s_nxt.r2 = `RST_R2;
      s_nxt.r3 = `RST_R3;
      s_nxt.r4 = `RST_R4;
      s_nxt.r5 = `RST_R5;
    end
    s_nxt.outs[0] = timing_int_n;
    s_nxt.outs[1] = ~(DAC_A_UNMUTE_PIN & s_r.r0[`BIT_UNMUTE_A]);
    s_nxt.outs[2] = ~(DAC_B_UNMUTE_PIN & s_r.r0[`BIT_UNMUTE_B]);
    s_nxt.outs[3] = s_r.r1[`BIT_ADC_PWR];
    s_nxt.outs[4] = s_r.r1[`BIT_DACA_PWR];
    s_nxt.outs[5] = s_r.r1[`BIT_DACB_PWR];
    // auto mode follows the detected clock rate instead of the speed bits
    s_nxt.outs[6] = s_r.r4[`BIT_PORTA_AUTO] ? PORT_A_CLK_DETECT : s_r.r4[5];
    s_nxt.outs[7] = s_r.r1[`BIT_PORTB_AUTO] ? PORT_B_CLK_DETECT : s_r.r1[1];
    s_nxt.outs[8] = 1'b0;
    s_nxt.outs[14:9] = 6'h00;
  end

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_r <= '{st: ST_IDLE, ph: PH_DEV, rd: 1'b0, bitc: 3'h0, sh: 8'h00,
               addr: 5'h00, oe: 1'b0, r0: `RST_R0, r1: `RST_R1, r2: `RST_R2,
               r3: `RST_R3, r4: `RST_R4, r5: `RST_R5, outs: 15'h003F};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // open drain: only ever pulls low
  assign SDA_OUT               = 1'b0;
  assign SDA_OE                = s_r.oe;
  assign CODEC_TIMING_RESET_N  = s_r.outs[0];
  assign DAC_A_MUTED           = s_r.outs[1];
  assign DAC_B_MUTED           = s_r.outs[2];
  assign ADC_POWER_ON          = s_r.outs[3];
  assign DAC_A_POWER_ON        = s_r.outs[4];
  assign DAC_B_POWER_ON        = s_r.outs[5];
  assign PORT_A_SPEED_HI       = s_r.outs[6];
  assign PORT_B_SPEED_HI       = s_r.outs[7];
  assign PORT_A_SPEED_SEL      = s_r.r4[5:4];
  assign PORT_B_SPEED_SEL      = s_r.r1[1:0];
  assign PORT_FORMAT_SEL       = s_r.r2[3:0];
  assign DAC_DEEMPH_SEL        = s_r.r3[7:4];
  assign PORT_A_MASTER_CLK_SEL = s_r.r4[2:0];
  assign MUTE_CLOCK_SRC_SEL    = s_r.r5[6:4];
  assign ADC_INPUT_SEL         = s_r.r5[3:0];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  addr_nack_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s_r.st == ST_ACK && s_r.ph == PH_DEV && s_r.sh[7:1] != MY_ADDR && scl_fall
     && !start_ev && !stop_ev) |=> !s_r.oe)
    else $error("acked foreign address");
  write_wrap_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s_r.st == ST_ACK && s_r.ph == PH_DATA && scl_fall && !s_r.oe && !start_ev
     && !stop_ev && s_r.addr == `WRITE_LAST_ADDR) |=> s_r.addr == 5'h00)
    else $error("write counter did not wrap");
  read_wrap_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    (s_r.st == ST_TX && scl_fall && s_r.bitc == 3'h7 && !start_ev && !stop_ev
     && s_r.addr == `READ_LAST_ADDR) |=> s_r.addr == 5'h00)
    else $error("read counter did not wrap");
  pdn_defaults_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    !POWERDOWN_PIN_N |=> s_r.r0 == `RST_R0 && s_r.r1 == `RST_R1)
    else $error("registers not defaulted");
  mute_pin_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    !DAC_A_UNMUTE_PIN |=> DAC_A_MUTED)
    else $error("dac a unmuted with pin low");
  fixed_zero_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    POWERDOWN_PIN_N |-> (s_r.r0 & ~`MASK_R0) == 8'h00)
    else $error("fixed zero bit set");
  release_ack_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    s_r.st == ST_TXACK |-> !s_r.oe)
    else $error("data line held during master ack");
  power_map_a: assert property (@(posedge CORE_CLK) disable iff (RST)
    ##1 ADC_POWER_ON == $past(s_r.r1[`BIT_ADC_PWR]))
    else $error("adc power does not follow register");
  read_cov_c: cover property (@(posedge CORE_CLK) s_r.st == ST_TX);
  write_cov_c: cover property (@(posedge CORE_CLK) s_r.st == ST_RX && s_r.ph == PH_DATA);
  wrap_cov_c: cover property (@(posedge CORE_CLK) s_r.st == ST_TXACK && s_r.addr == 5'h00);
endmodule

// file: tb/i2c_master_model.sv
// bus master model that drives the serial control pins of the codec
`timescale 1ns/1ps
module i2c_master_model (
  // clock
  input  wire logic clk,
  // bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_pull_low
);
  // -------------------------------------------------
  // bit timing
  // -------------------------------------------------
  // high time of the clock line; raise it to act as a slow master
  int unsigned high_cyc = 8;

  initial begin
    scl          = 1'b1;
    sda_pull_low = 1'b0;
  end

  task automatic wait_cyc(input int unsigned n);
    repeat (n) @(posedge clk);
  endtask

  // data moves only while the clock line is low; the line is read late in
  // the high phase so a slave that answers slowly is still seen
  task automatic bit_io(input logic b, output logic seen);
    wait_cyc(3);
    sda_pull_low <= ~b;
    wait_cyc(5);
    scl <= 1'b1;
    wait_cyc(high_cyc);
    seen = sda;
    scl <= 1'b0;
  endtask

  task automatic start_cond();
    wait_cyc(3);
    sda_pull_low <= 1'b0;
    wait_cyc(5);
    scl <= 1'b1;
    wait_cyc(high_cyc);
    sda_pull_low <= 1'b1;
    wait_cyc(high_cyc);
    scl <= 1'b0;
  endtask

  task automatic stop_cond();
    wait_cyc(3);
    sda_pull_low <= 1'b1;
    wait_cyc(5);
    scl <= 1'b1;
    wait_cyc(high_cyc);
    sda_pull_low <= 1'b0;
    wait_cyc(high_cyc);
  endtask

  // one byte out, MSB first; acked is high when the slave pulled the line
  task automatic send_byte(input logic [7:0] d, output logic acked);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], seen);
    end
    bit_io(1'b1, seen);
    acked = ~seen;
  endtask

  // one byte in; ack asks for the next byte, ack_seen is the line level
  task automatic recv_byte(input logic ack, output logic [7:0] d, output logic ack_seen);
    logic seen;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, seen);
      d[i] = seen;
    end
    bit_io(~ack, ack_seen);
  endtask
endmodule

// file: tb/testbench.sv
// self-checking bench for the codec serial control port
`timescale 1ns/1ps
module testbench;
  // -------------------------------------------------
  // setup
  // -------------------------------------------------
  // arbitrary identity value; chip bits fixed at 10
  localparam logic [4:0] ID_SEL = 5'h0B;
  localparam logic [7:0] ADDR_W = {ID_SEL, 2'b10, 1'b0};
  localparam logic [7:0] ADDR_R = {ID_SEL, 2'b10, 1'b1};
  localparam logic [7:0] DEF [0:5] = '{8'h01, 8'h70, 8'h0F, 8'h50, 8'h00, 8'h10};
  localparam int LIMIT = 60000;

  logic       core_clk, rst, scl, sda_pull_low, sda_oe, pd_n, sda_out;
  logic       pin_a, pin_b, det_a, det_b, trst_n, mute_a, mute_b;
  logic       adc_on, dac_a_on, dac_b_on, hi_a, hi_b, nack_lvl;
  logic [1:0] sel_a, sel_b;
  logic [2:0] cks, mts;
  logic [3:0] ain, fmt, dem;
  logic [7:0] rbuf [0:15];
  int         failures = 0;
  int         checks = 0;
  int         cycles = 0;
  // the line has a pull-up: released means high
  wire        sda = ~(sda_oe | sda_pull_low);

  codec_i2c_control_regs #(.ID_CODE(ID_SEL)) i_codec_i2c_control_regs (
    .CORE_CLK(core_clk), .RST(rst), .SCL(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe),
    .POWERDOWN_PIN_N(pd_n), .DAC_A_UNMUTE_PIN(pin_a), .DAC_B_UNMUTE_PIN(pin_b),
    .PORT_A_CLK_DETECT(det_a), .PORT_B_CLK_DETECT(det_b), .CODEC_TIMING_RESET_N(trst_n),
    .DAC_A_MUTED(mute_a), .DAC_B_MUTED(mute_b), .ADC_POWER_ON(adc_on),
    .DAC_A_POWER_ON(dac_a_on), .DAC_B_POWER_ON(dac_b_on), .PORT_A_SPEED_HI(hi_a),
    .PORT_B_SPEED_HI(hi_b), .PORT_A_SPEED_SEL(sel_a), .PORT_B_SPEED_SEL(sel_b),
    .PORT_FORMAT_SEL(fmt), .DAC_DEEMPH_SEL(dem), .PORT_A_MASTER_CLK_SEL(cks),
    .MUTE_CLOCK_SRC_SEL(mts), .ADC_INPUT_SEL(ain));

  i2c_master_model master (.clk(core_clk), .sda(sda), .scl(scl), .sda_pull_low(sda_pull_low));

  // -------------------------------------------------
  // compare, verdict and bus helpers
  // -------------------------------------------------
  task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // up to four data bytes, first byte in the top bits of d
  task automatic write_regs(input logic [7:0] ra, input logic [31:0] d, input int n);
    logic a;
    master.start_cond();
    master.send_byte(ADDR_W, a);
    check1("write addr ack", 1'b1, a);
    master.send_byte(ra, a);
    check1("reg addr ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      master.send_byte(d[31 - 8 * i -: 8], a);
      check1("data ack", 1'b1, a);
    end
    master.stop_cond();
  endtask

  // random read when rnd is set, current address read otherwise
  task automatic read_regs(input logic rnd, input logic [7:0] ra, input int n);
    logic a;
    if (rnd) begin
      master.start_cond();
      master.send_byte(ADDR_W, a);
      master.send_byte(ra, a);
    end
    master.start_cond();
    master.send_byte(ADDR_R, a);
    check1("read addr ack", 1'b1, a);
    for (int i = 0; i < n; i++) begin
      master.recv_byte(i < n - 1, rbuf[i], nack_lvl);
    end
    master.stop_cond();
    check1("line free on nack", 1'b1, nack_lvl);
  endtask

  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic t_defaults();
    read_regs(1'b1, 8'h00, 16);
    for (int i = 0; i < 16; i++) begin
      check8("read wrap", (i < 6) ? DEF[i] : (i > 13) ? DEF[i - 14] : 8'h00, rbuf[i]);
    end
    read_regs(1'b0, 8'h00, 1);
    check8("current after wrap", 8'h0F, rbuf[0]);
    check1("muted bit clear", 1'b1, mute_a);
    check1("adc power", 1'b1, adc_on);
    check1("timing run", 1'b1, trst_n);
  endtask

  task automatic t_bad_addr();
    logic a;
    logic [7:0] bad [0:1];
    bad = '{{ID_SEL, 2'b01, 1'b0}, {ID_SEL ^ 5'h10, 2'b10, 1'b1}};
    foreach (bad[i]) begin
      master.start_cond();
      master.send_byte(bad[i], a);
      master.stop_cond();
      check1("foreign addr ack", 1'b0, a);
    end
  endtask

  task automatic t_write_wrap();
    @(posedge core_clk);
    pin_b <= 1'b0;
    det_b <= 1'b1;
    write_regs(8'hE4, 32'h672A0704, 4);
    read_regs(1'b0, 8'h00, 1);
    check8("current after write", 8'h0F, rbuf[0]);
    read_regs(1'b1, 8'h04, 2);
    check8("reg4", 8'h67, rbuf[0]);
    check8("reg5", 8'h2A, rbuf[1]);
    read_regs(1'b1, 8'h00, 2);
    check8("reg0 wrapped", 8'h07, rbuf[0]);
    check8("reg1 wrapped", 8'h04, rbuf[1]);
    check1("a unmuted", 1'b0, mute_a);
    check1("b pin low", 1'b1, mute_b);
    check1("adc off", 1'b0, adc_on);
    check1("dac a off", 1'b0, dac_a_on);
    check1("dac b off", 1'b0, dac_b_on);
    check1("a auto", 1'b0, hi_a);
    check1("b auto", 1'b1, hi_b);
    check8("a speed field", 8'h02, {6'h00, sel_a});
    check8("input field", 8'h0A, {4'h0, ain});
    check8("clock sel field", 8'h07, {5'h00, cks});
    check8("mute src field", 8'h02, {5'h00, mts});
    @(posedge core_clk);
    det_a <= 1'b1;
    repeat (4) @(posedge core_clk);
    check1("a auto detect", 1'b1, hi_a);
  endtask

  task automatic t_manual_speed();
    write_regs(8'h01, 32'h71000000, 1);
    check1("b manual low", 1'b0, hi_b);
    write_regs(8'h01, 32'h72000000, 1);
    check1("b manual high", 1'b1, hi_b);
    check8("b speed field", 8'h02, {6'h00, sel_b});
    check1("dac b on", 1'b1, dac_b_on);
  endtask

  task automatic t_partial();
    logic a;
    master.start_cond();
    master.send_byte(ADDR_W, a);
    master.send_byte(8'h02, a);
    for (int i = 0; i < 4; i++) begin
      master.bit_io(1'b0, a);
    end
    master.stop_cond();
    read_regs(1'b1, 8'h02, 1);
    check8("cut byte", 8'h0F, rbuf[0]);
  endtask

  // the delay is counted from the register write, which lands shortly
  // before the stop, so both sample points leave some margin
  task automatic t_timing_reset();
    @(posedge core_clk);
    pin_b <= 1'b1;
    write_regs(8'h00, 32'h06000000, 1);
    repeat (3900) @(posedge core_clk);
    check1("timing reset early", 1'b1, trst_n);
    repeat (500) @(posedge core_clk);
    check1("timing reset late", 1'b0, trst_n);
    read_regs(1'b1, 8'h00, 2);
    check8("reg0 kept", 8'h06, rbuf[0]);
    check8("reg1 kept", 8'h72, rbuf[1]);
    check1("mute kept", 1'b0, mute_a);
    check1("b unmuted", 1'b0, mute_b);
    write_regs(8'h00, 32'h07000000, 1);
    check1("timing back", 1'b1, trst_n);
  endtask

  task automatic t_powerdown();
    @(posedge core_clk);
    pd_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    pd_n <= 1'b1;
    read_regs(1'b1, 8'h00, 6);
    for (int i = 0; i < 6; i++) begin
      check8("reg after pin", DEF[i], rbuf[i]);
    end
    check1("muted after pin", 1'b1, mute_a);
    check1("adc after pin", 1'b1, adc_on);
    check8("format after pin", 8'h0F, {4'h0, fmt});
    check8("deemph after pin", 8'h05, {4'h0, dem});
    check8("mute src after pin", 8'h01, {5'h00, mts});
    check1("a manual after pin", 1'b0, hi_a);
    check1("sda out level", 1'b0, sda_out);
  endtask

  // -------------------------------------------------
  // clock, timeout and main sequence
  // -------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      print_verdict();
    end
  end

  initial begin
    rst   = 1'b1;
    pd_n  = 1'b1;
    pin_a = 1'b1;
    pin_b = 1'b1;
    det_a = 1'b0;
    det_b = 1'b0;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_defaults();
    t_bad_addr();
    t_write_wrap();
    t_manual_speed();
    t_partial();
    t_timing_reset();
    t_powerdown();
    print_verdict();
  end
endmodule
